// ==== ctw_pkg.sv ====
// ctw_pkg: constants and types for the core tick chain with watchdog
package ctw_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] CTW_IDX_CTRL = 4'h8;
  localparam logic [3:0] CTW_IDX_COUNT = 4'h9;
  localparam logic [3:0] CTW_IDX_SERVICE = 4'hA;
  localparam logic [3:0] CTW_IDX_OPTION = 4'hB;
  // control/status field positions
  localparam int CTW_BIT_OVF_F = 7;
  localparam int CTW_BIT_PER_F = 6;
  localparam int CTW_BIT_OVF_EN = 5;
  localparam int CTW_BIT_PER_EN = 4;
  localparam int CTW_BIT_SEL_HI = 1;
  localparam int CTW_BIT_SEL_LO = 0;
  // option register: watchdog enable position
  localparam int CTW_BIT_WD_EN = 0;
  // reset values
  localparam logic [1:0] CTW_SEL_RST = 2'h3;
  localparam logic CTW_WD_EN_RST = 1'b0;
  // chain geometry
  localparam int CTW_CHAIN_W = 17;
  localparam int CTW_PRE_W = 2;
  localparam int CTW_TICK_W = 8;
  localparam int CTW_WD_W = 3;
  // power-on interval in bus clock periods
  localparam int CTW_POR_CYCLES = 4064;
  localparam logic [CTW_CHAIN_W-1:0] CTW_POR_LAST =
    CTW_CHAIN_W'(CTW_POR_CYCLES - 1);
  // ahb encodings
  localparam logic [2:0] CTW_HSIZE_WORD = 3'h2;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    CTW_ST_POR = 3'b001,
    CTW_ST_HOLD = 3'b010,
    CTW_ST_RUN = 3'b100
  } ctw_state_type;
  // interrupt request pair
  typedef struct packed {
    logic ovf;
    logic per;
  } ctw_irq_type;
  // whole module state
  typedef struct packed {
    ctw_state_type st;
    logic [CTW_CHAIN_W-1:0] cnt;
    logic ovf_f;
    logic per_f;
    logic ovf_en;
    logic per_en;
    logic [1:0] sel;
    logic wd_en;
    logic [CTW_WD_W-1:0] wd;
    logic wd_rst;
    logic dev_rst;
    ctw_irq_type irq;
    logic pend;
    logic pend_wr;
    logic pend_ok;
    logic [3:0] pend_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } ctw_regs_type;
endpackage : ctw_pkg

// ==== ctw_core_tick.sv ====
// ctw_core_tick: core tick chain, periodic tick and watchdog behind AHB-Lite
//
// Functional notes
// (R01) prescale bus clock by four into counter
// (R02) tick count register reads live counter
// (R03) overflow every 1024 bus clocks
// (R04) power-on interval 4064 bus clocks from chain
// (R05) four stages give periodic clock bus/16384
// (R06) three stages and one-of-four rate selector
// (R07) watchdog counts periodic ticks divided by eight
// (R08) overflow flag on wrap, irq with enable
// (R09) write zero clears overflow flag; reset clears
// (R10) periodic flag on tap, clear by zero
// (R11) power-on clears chain twice, then counts
// (R12) external reset clears the whole chain
// (R13) watchdog only when enabled; timeout resets
// (R14) software writes zero to service bit 0
// (R15) service clears only final eight stage
// (R16) rate, enables, flags in one register
// (R17) reset sets both rate-select bits
// (R18) reset clears tick count register
// (R19) set event beats a clearing write
`timescale 1ns/1ps
`default_nettype none
module ctw_core_tick (
  // clock and power-on reset
  input wire logic CLK,
  input wire logic RSTN,
  // external reset pin, active low level
  input wire logic EXT_RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // interrupt requests
  output ctw_pkg::ctw_irq_type IRQ,
  // watchdog timeout pulse and device-in-reset level
  output logic WDOG_RST,
  output logic DEV_RST
);
  import ctw_pkg::*;

  // registered and next state
  ctw_regs_type s_q;
  ctw_regs_type s_d;
  // decoded address phase
  logic addr_take;
  // data phase write strobes
  logic wr_ctrl;
  logic wr_svc;
  logic wr_opt;
  // chain events
  logic ovf_hit;
  logic per_hit;
  logic wd_expire;
  // register read image
  logic [7:0] ctrl_img;

  // address phase accepted when selected, active and bus ready
  assign addr_take = HSEL && HTRANS[1] && HREADY;

  // write strobes in the data phase
  assign wr_ctrl = s_q.pend && s_q.pend_wr && s_q.pend_ok &&
                   (s_q.pend_idx == CTW_IDX_CTRL);
  assign wr_svc = s_q.pend && s_q.pend_wr && s_q.pend_ok &&
                  (s_q.pend_idx == CTW_IDX_SERVICE);
  assign wr_opt = s_q.pend && s_q.pend_wr && s_q.pend_ok &&
                  (s_q.pend_idx == CTW_IDX_OPTION);

  // (R03) last counter stage wraps
  assign ovf_hit = (s_q.st == CTW_ST_RUN) &&
                   (&s_q.cnt[CTW_PRE_W+CTW_TICK_W-1:0]);

  // periodic tap selection
  always_comb begin
    // (R05) (R06) four taps after fixed stages
    case (s_q.sel)
      2'h0: per_hit = &s_q.cnt[13:0];
      2'h1: per_hit = &s_q.cnt[14:0];
      2'h2: per_hit = &s_q.cnt[15:0];
      default: per_hit = &s_q.cnt[16:0];
    endcase
    per_hit = per_hit && (s_q.st == CTW_ST_RUN);
  end

  // (R07) (R13) eighth periodic tick expires watchdog
  assign wd_expire = per_hit && s_q.wd_en && (&s_q.wd) && !wr_svc;

  // control/status read image, bits 3:2 read zero
  always_comb begin
    ctrl_img = 8'h00;
    // (R16) one register holds rate, enables, flags
    ctrl_img[CTW_BIT_OVF_F] = s_q.ovf_f;
    ctrl_img[CTW_BIT_PER_F] = s_q.per_f;
    ctrl_img[CTW_BIT_OVF_EN] = s_q.ovf_en;
    ctrl_img[CTW_BIT_PER_EN] = s_q.per_en;
    ctrl_img[CTW_BIT_SEL_HI] = s_q.sel[1];
    ctrl_img[CTW_BIT_SEL_LO] = s_q.sel[0];
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wd_rst = 1'b0;
    // bus slave: one wait state per transfer
    if (s_q.pend) begin
      // data phase: answer ready next cycle
      s_d.pend = 1'b0;
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (!s_q.pend_wr && s_q.pend_ok) begin
        case (s_q.pend_idx)
          CTW_IDX_CTRL: s_d.rdata = {24'h00_0000, ctrl_img};
          // (R02) live counter value
          CTW_IDX_COUNT: begin
            s_d.rdata = {24'h00_0000,
                         s_q.cnt[CTW_PRE_W+CTW_TICK_W-1:CTW_PRE_W]};
          end
          CTW_IDX_OPTION: s_d.rdata = {31'h0000_0000, s_q.wd_en};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end else if (addr_take) begin
      // capture address phase, stall the bus
      s_d.pend = 1'b1;
      s_d.ready = 1'b0;
      s_d.pend_wr = HWRITE;
      s_d.pend_idx = HADDR[5:2];
      s_d.pend_ok = (HADDR[31:6] == 26'h000_0000) &&
                    (HADDR[1:0] == 2'h0) && (HSIZE == CTW_HSIZE_WORD);
    end

    // control writes
    if (wr_ctrl) begin
      // (R09) zero clears overflow flag, one keeps it
      if (!HWDATA[CTW_BIT_OVF_F]) begin
        s_d.ovf_f = 1'b0;
      end
      // (R10) zero clears periodic flag
      if (!HWDATA[CTW_BIT_PER_F]) begin
        s_d.per_f = 1'b0;
      end
      s_d.ovf_en = HWDATA[CTW_BIT_OVF_EN];
      s_d.per_en = HWDATA[CTW_BIT_PER_EN];
      s_d.sel = {HWDATA[CTW_BIT_SEL_HI], HWDATA[CTW_BIT_SEL_LO]};
    end
    // option register steers the watchdog
    if (wr_opt) begin
      s_d.wd_en = HWDATA[CTW_BIT_WD_EN];
    end

    // (R19) set events come after clears
    if (ovf_hit) begin
      // (R08) wrap sets overflow flag
      s_d.ovf_f = 1'b1;
    end
    if (per_hit) begin
      // (R10) selected tap sets periodic flag
      s_d.per_f = 1'b1;
    end

    // (R01) chain advances every bus clock, prescaler low bits
    s_d.cnt = s_q.cnt + CTW_CHAIN_W'(1);

    // watchdog divide-by-eight
    if (wr_svc && !HWDATA[0]) begin
      // (R14) (R15) service clears only final stage
      s_d.wd = '0;
    end else if (per_hit && s_q.wd_en) begin
      s_d.wd = s_q.wd + CTW_WD_W'(1);
    end

    // sequencer
    case (s_q.st)
      CTW_ST_POR: begin
        // (R04) (R11) interval taken from chain
        if (s_q.cnt == CTW_POR_LAST) begin
          s_d.cnt = '0;
          s_d.st = EXT_RST_N ? CTW_ST_RUN : CTW_ST_HOLD;
          s_d.dev_rst = !EXT_RST_N;
        end
      end
      CTW_ST_HOLD: begin
        // (R12) chain held clear while pin asserted
        s_d.cnt = '0;
        if (EXT_RST_N) begin
          s_d.st = CTW_ST_RUN;
          s_d.dev_rst = 1'b0;
        end
      end
      CTW_ST_RUN: begin
        if (!EXT_RST_N) begin
          s_d.st = CTW_ST_HOLD;
          s_d.dev_rst = 1'b1;
        end
      end
      default: begin
        s_d.st = CTW_ST_POR;
        s_d.cnt = '0;
      end
    endcase

    // external reset or watchdog reset clears chain, control register and watchdog stage, keeps option
    if ((s_q.st != CTW_ST_POR && !EXT_RST_N) || wd_expire) begin
      // (R12) (R18) (R09) (R17) device reset values
      s_d.cnt = '0;
      s_d.ovf_f = 1'b0;
      s_d.per_f = 1'b0;
      s_d.ovf_en = 1'b0;
      s_d.per_en = 1'b0;
      s_d.sel = CTW_SEL_RST;
      s_d.wd = '0;
    end
    if (wd_expire) begin
      // (R13) timeout raises internal reset
      s_d.wd_rst = 1'b1;
    end

    // (R08) requests follow flag and enable
    s_d.irq.ovf = s_d.ovf_f && s_d.ovf_en;
    s_d.irq.per = s_d.per_f && s_d.per_en;
    s_d.resp = 1'b0;
  end

  // state register, synchronous power-on reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      // (R11) (R17) (R18) power-on clears chain and registers
      s_q <= '0;
      s_q.st <= CTW_ST_POR;
      s_q.sel <= CTW_SEL_RST;
      s_q.wd_en <= CTW_WD_EN_RST;
      s_q.dev_rst <= 1'b1;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = s_q.ready;
  assign HRESP = s_q.resp;
  assign IRQ = s_q.irq;
  assign WDOG_RST = s_q.wd_rst;
  assign DEV_RST = s_q.dev_rst;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // service write sequence in data phase
  sequence s_service;
    wr_svc && !HWDATA[0];
  endsequence

  // overflow wrap and its flag
  sequence s_wrap;
    ovf_hit ##1 s_q.ovf_f;
  endsequence

  // (R17) reset values
  AST_RESET_VALUES: assert property (disable iff (1'b0) // (R17)
    !RSTN |=> (s_q.sel == CTW_SEL_RST) && !s_q.ovf_f && !s_q.per_f &&
      !s_q.ovf_en && (s_q.cnt == '0))
    else $error("reset values wrong");

  // chain clears that cut a prescale window short
  logic chain_cut;
  assign chain_cut = !RSTN || !EXT_RST_N || wd_expire;

  // (R01) counter advances once per four bus clocks
  AST_PRESCALE: assert property (disable iff (chain_cut) // (R01)
    (s_q.st == CTW_ST_RUN) && EXT_RST_N && !wd_expire &&
      (s_q.cnt[1:0] == 2'h0) |=>
      $stable(s_q.cnt[9:2]) [*3] ##1 !$stable(s_q.cnt[9:2]))
    else $error("tick count not divided by four");

  // (R08) wrap sets overflow flag
  AST_OVF_SET: assert property ( // (R08)
    ovf_hit && EXT_RST_N && !wd_expire |-> s_wrap)
    else $error("overflow flag not set on wrap");

  // (R08) request matches flag and enable
  AST_OVF_IRQ: assert property ( // (R08)
    IRQ.ovf == (s_q.ovf_f && s_q.ovf_en))
    else $error("overflow request mismatch");

  // (R19) set wins over clearing write
  AST_SET_WINS: assert property ( // (R19)
    wr_ctrl && !HWDATA[CTW_BIT_PER_F] && per_hit && EXT_RST_N &&
      !wd_expire |=> s_q.per_f)
    else $error("periodic set lost to clear");

  // (R09) zero write clears idle overflow flag
  AST_OVF_CLR: assert property ( // (R09)
    wr_ctrl && !HWDATA[CTW_BIT_OVF_F] && !ovf_hit |=> !s_q.ovf_f)
    else $error("overflow flag not cleared");

  // (R04) power-on interval ends with cleared chain
  AST_POR_END: assert property ( // (R04)
    (s_q.st == CTW_ST_POR) && (s_q.cnt == CTW_POR_LAST) |=>
      (s_q.cnt == '0) && (s_q.st != CTW_ST_POR))
    else $error("power-on interval end wrong");

  // (R12) external reset clears chain
  AST_EXT_CLR: assert property ( // (R12)
    (s_q.st == CTW_ST_RUN) && !EXT_RST_N |=>
      (s_q.cnt == '0) && DEV_RST)
    else $error("external reset did not clear chain");

  // (R15) service clears watchdog stage
  AST_SERVICE: assert property ( // (R15)
    s_service |=> (s_q.wd == '0) && !WDOG_RST)
    else $error("service did not clear watchdog");

  // (R13) disabled watchdog never fires
  AST_WD_OFF: assert property ( // (R13)
    !s_q.wd_en |=> !WDOG_RST)
    else $error("watchdog fired while disabled");

  // (R10) periodic tap sets flag
  AST_PER_SET: assert property ( // (R10)
    per_hit && EXT_RST_N && !wd_expire |=> s_q.per_f)
    else $error("periodic flag not set");
endmodule : ctw_core_tick
`default_nettype wire

// ==== testbench.sv ====
// testbench: self-checking bench for the core tick chain block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ctw_pkg::*;
  // clock, resets and bus wires
  logic clk, rstn, ext_rst_n, hsel, hwrite, hreadyout, hresp;
  logic wdog_rst, dev_rst, wd_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ctw_irq_type irq;
  int err_total, total_checks;
  time t0, t1, t2;

  // device under test, slave ready fed back as bus ready
  ctw_core_tick dut_u (
    .CLK(clk), .RSTN(rstn), .EXT_RST_N(ext_rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .IRQ(irq), .WDOG_RST(wdog_rst), .DEV_RST(dev_rst)
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // remember any watchdog reset pulse
  always @(posedge clk) begin
    if (rstn !== 1'b1) begin
      wd_seen <= 1'b0;
    end else if (wdog_rst === 1'b1) begin
      wd_seen <= 1'b1;
    end
  end

  // print counts and verdict, then stop
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  // a wait ran out: count it and close the run
  task bail(input string m);
    err_total++;
    $display("unexpected %0t: %s", $time, m);
    summarize();
  endtask : bail

  // one single-word transfer: address phase, then data phase
  task bus(input logic w, input logic [3:0] idx, input logic [31:0] wd,
           output logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= CTW_HSIZE_WORD;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) bail("bus wait ran out");
    d = hrdata;
  endtask : bus

  // register write
  task wr(input logic [3:0] idx, input logic [31:0] v);
    bus(1'b1, idx, v, rd);
  endtask : wr

  // register read and compare
  task rdc(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rd);
    chk(rd, exp, "register read");
    chk(32'(hresp), 0, "bus response");
  endtask : rdc

  // let some clock edges pass
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // wait for an interrupt level, note the edge it was seen
  task wait_irq(input logic per, input int lim, output time t);
    int n;
    n = 0;
    while ((per ? irq.per : irq.ovf) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) bail("interrupt wait ran out");
    t = $time;
  endtask : wait_irq

  // reset values, unmapped place, power-on interval
  task t_reset;
    int n;
    n = 0;
    rdc(CTW_IDX_CTRL, 32'h03);
    rdc(CTW_IDX_OPTION, 32'h00);
    rdc(4'h3, 32'h00);
    while (dev_rst !== 1'b0 && n < 5000) begin @(posedge clk); n++; end
    chk(32'(int'((($time - t0) / 10)) inside {[4064:4068]}), 1, "por");
    $display("test reset done");
  endtask : t_reset

  // overflow period, clear by zero, keep by one, enable gating
  task t_ovf;
    wr(CTW_IDX_CTRL, 32'h23);
    wait_irq(1'b0, 1200, t1);
    wr(CTW_IDX_CTRL, 32'h23);
    tick(2);
    chk(32'(irq.ovf), 0, "ovf irq after clear");
    wait_irq(1'b0, 1100, t2);
    chk(32'((t2 - t1) / 10), 1024, "ovf period");
    rdc(CTW_IDX_CTRL, 32'hA3);
    wr(CTW_IDX_CTRL, 32'h83);
    tick(2);
    chk(32'(irq.ovf), 0, "ovf irq disabled");
    rdc(CTW_IDX_CTRL, 32'h83);
    $display("test overflow done");
  endtask : t_ovf

  // fastest periodic rate, flag clear, watchdog stays quiet
  task t_per;
    wr(CTW_IDX_CTRL, 32'h10);
    wait_irq(1'b1, 16500, t1);
    wr(CTW_IDX_CTRL, 32'h10);
    tick(2);
    chk(32'(irq.per), 0, "per irq after clear");
    wait_irq(1'b1, 16500, t2);
    chk(32'((t2 - t1) / 10), 16384, "periodic period");
    rdc(CTW_IDX_CTRL, 32'hD0);
    chk(32'(irq.ovf), 0, "ovf irq masked");
    chk(32'(wd_seen), 0, "watchdog while disabled");
    $display("test periodic done");
  endtask : t_per

  // external reset clears chain and control, keeps option
  task t_ext;
    int p;
    wr(CTW_IDX_OPTION, 32'h01);
    rdc(CTW_IDX_OPTION, 32'h01);
    wr(CTW_IDX_SERVICE, 32'h00);
    wr(CTW_IDX_CTRL, 32'h30);
    ext_rst_n <= 1'b0;
    tick(3);
    chk(32'(dev_rst), 1, "device held in reset");
    chk(32'(irq), 0, "irq in reset");
    rdc(CTW_IDX_CTRL, 32'h03);
    wr(CTW_IDX_COUNT, 32'hFF);
    rdc(CTW_IDX_COUNT, 32'h00);
    rdc(CTW_IDX_OPTION, 32'h01);
    ext_rst_n <= 1'b1;
    t0 = $time;
    tick(3);
    chk(32'(dev_rst), 0, "device out of reset");
    tick(40);
    bus(1'b0, CTW_IDX_COUNT, 32'h0, rd);
    chk(32'(rd inside {[1:30]}), 1, "count runs by four");
    wr(CTW_IDX_CTRL, 32'h12);
    rdc(CTW_IDX_CTRL, 32'h12);
    wr(CTW_IDX_CTRL, 32'h11);
    wait_irq(1'b1, 33000, t1);
    p = int'((t1 - t0) / 10);
    chk(32'(p inside {[32768:32772]}), 1, "second rate");
    chk(32'(wd_seen), 0, "watchdog serviced");
    $display("test external reset done");
  endtask : t_ext

  // main sequence
  initial begin
    rstn = 1'b0;
    ext_rst_n = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = CTW_HSIZE_WORD;
    hwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t0 = $time;
    t_reset();
    t_ovf();
    t_per();
    t_ext();
    summarize();
  end

  // cut a hang short
  initial begin
    #1000000;
    bail("run ran out of time");
  end
endmodule : testbench
`default_nettype wire
